// ==== src/scsb_consts.svh ====
// constants for the serial clock select and baud rate divider block
`ifndef SCSB_CONSTS_SVH
`define SCSB_CONSTS_SVH

// ==========================================
// timing
`define SCSB_CLOCK_KHZ 40000
`define SCSB_SETTLE_MS 20
`define SCSB_SETTLE_CYCLES (`SCSB_SETTLE_MS * `SCSB_CLOCK_KHZ)
`define SCSB_SETTLE_WIDTH 20

// ==========================================
// register byte offsets (low address byte)
`define SCSB_OFS_CLOCK_MODE 8'h00
`define SCSB_OFS_CONST_LOW 8'h04
`define SCSB_OFS_CONST_HIGH 8'h08
`define SCSB_OFS_DIV_CONTROL 8'h0c
`define SCSB_OFS_STATUS 8'h10

// ==========================================
// reset values
`define SCSB_CLOCK_MODE_RESET 8'h08
`define SCSB_DIV_CONTROL_RESET 8'h00
`define SCSB_CONST_RESET 16'h0000

// ==========================================
// field positions
`define SCSB_DIVCTL_ENABLE 0
`define SCSB_DIVCTL_SOURCE 1
`define SCSB_STAT_PIN_OE 0
`define SCSB_STAT_DIV_OUT 1
`define SCSB_STAT_SETTLED 2
`define SCSB_STAT_XTAL 3
`define SCSB_STAT_RUNNING 4
`define SCSB_STAT_COUNT_LSB 16

// ==========================================
// divider start delay in counts
`define SCSB_START_COUNTS 2'h2

`endif

// ==== src/scsb_pkg.sv ====
// types for the serial clock select and baud rate divider block
package scsb_pkg;

    // ==========================================
    // clock source select codes
    typedef enum logic [1:0] {
        SRC_PRIMARY = 2'b00,
        SRC_SECONDARY = 2'b01,
        SRC_DIVIDER = 2'b10,
        SRC_PLL = 2'b11
    } scsb_src_type;

    // secondary pin output source codes
    typedef enum logic [1:0] {
        OUT_OSC = 2'b00,
        OUT_TX_CLOCK = 2'b01,
        OUT_DIVIDER = 2'b10,
        OUT_PLL_RX = 2'b11
    } scsb_out_type;

    // clock mode control register layout
    typedef struct packed {
        logic xtal_select;
        scsb_src_type rx_select;
        scsb_src_type tx_select;
        logic pin_direction;
        scsb_out_type out_select;
    } scsb_mode_type;

    // divider state
    typedef enum logic [1:0] {
        DIV_STOP = 2'b00,
        DIV_ARM = 2'b01,
        DIV_RUN = 2'b10
    } scsb_div_state_type;

    // external clock levels after synchronising
    typedef struct packed {
        logic primary;
        logic oscillator;
        logic framing;
        logic secondary;
    } scsb_pins_type;

endpackage

// ==== src/scsb_sync.sv ====
// three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
module scsb_sync #(
    parameter int WIDTH = 4
) (
    input wire logic clock,
    input wire logic reset_n,
    input wire logic [WIDTH-1:0] pin_in,
    output logic [WIDTH-1:0] level_out
);

    logic [WIDTH-1:0] stage1_ff;
    logic [WIDTH-1:0] stage2_ff;
    logic [WIDTH-1:0] stage3_ff;
    logic [WIDTH-1:0] level_ff;
    logic [WIDTH-1:0] agree;
    logic [WIDTH-1:0] nxt_level;

    // a bit changes only once stages two and three agree
    assign agree = ~(stage2_ff ^ stage3_ff);
    assign nxt_level = (stage3_ff & agree) | (level_ff & ~agree);
    assign level_out = level_ff;

    // shift chain
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            stage1_ff <= '0;
            stage2_ff <= '0;
            stage3_ff <= '0;
            level_ff <= '0;
        end else begin
            stage1_ff <= pin_in;
            stage2_ff <= stage1_ff;
            stage3_ff <= stage2_ff;
            level_ff <= nxt_level;
        end
    end

endmodule

// ==== src/scsb_divider.sv ====
// sixteen-bit reloading down counter with toggle output
`timescale 1ns/1ps
`include "scsb_consts.svh"
module scsb_divider (
    input wire logic clock,
    input wire logic reset_n,
    input wire logic tick,
    input wire logic enable,
    input wire logic [15:0] time_constant,
    output logic divider_out,
    output logic running,
    output logic [15:0] count
);

    scsb_pkg::scsb_div_state_type state_ff;
    scsb_pkg::scsb_div_state_type nxt_state;
    logic [15:0] count_ff;
    logic [15:0] nxt_count;
    logic reload_ff;
    logic nxt_reload;
    logic toggle_ff;
    logic nxt_toggle;
    logic [1:0] arm_ff;
    logic [1:0] nxt_arm;
    logic counting;
    logic at_zero;

    assign at_zero = (count_ff == 16'h0000);
    assign counting = (state_ff != scsb_pkg::DIV_STOP) && tick;
    assign divider_out = toggle_ff;
    assign running = (state_ff == scsb_pkg::DIV_RUN);
    assign count = count_ff;

    // count n..0, one reload tick, toggle at terminal count
    // constant only sampled on reload
    always_comb begin
        nxt_count = count_ff;
        nxt_reload = reload_ff;
        nxt_toggle = toggle_ff;
        if (!enable) begin
            nxt_reload = 1'b1;
        end else if (counting) begin
            if (reload_ff) begin
                nxt_count = time_constant;
                nxt_reload = 1'b0;
            end else if (at_zero) begin
                nxt_reload = 1'b1;
                if (state_ff == scsb_pkg::DIV_RUN) begin
                    nxt_toggle = ~toggle_ff;
                end
            end else begin
                nxt_count = count_ff - 16'h0001;
            end
        end
    end

    // enable: two counts before output reacts, stop at once
    always_comb begin
        nxt_state = state_ff;
        nxt_arm = arm_ff;
        unique case (state_ff)
            scsb_pkg::DIV_STOP: begin
                nxt_arm = 2'h0;
                if (enable) begin
                    nxt_state = scsb_pkg::DIV_ARM;
                end
            end
            scsb_pkg::DIV_ARM: begin
                if (!enable) begin
                    nxt_state = scsb_pkg::DIV_STOP;
                end else if (tick) begin
                    nxt_arm = arm_ff + 2'h1;
                    if (arm_ff + 2'h1 == `SCSB_START_COUNTS) begin
                        nxt_state = scsb_pkg::DIV_RUN;
                    end
                end
            end
            scsb_pkg::DIV_RUN: begin
                if (!enable) begin
                    nxt_state = scsb_pkg::DIV_STOP;
                end
            end
            default: begin
                nxt_state = scsb_pkg::DIV_STOP;
            end
        endcase
    end

    // state registers
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            state_ff <= scsb_pkg::DIV_STOP;
            count_ff <= `SCSB_CONST_RESET;
            reload_ff <= 1'b1;
            toggle_ff <= 1'b0;
            arm_ff <= 2'h0;
        end else begin
            state_ff <= nxt_state;
            count_ff <= nxt_count;
            reload_ff <= nxt_reload;
            toggle_ff <= nxt_toggle;
            arm_ff <= nxt_arm;
        end
    end

endmodule

// ==== src/scsb_top.sv ====
// clock selection, secondary pin control and baud rate divider with ahb-lite registers
`timescale 1ns/1ps
`include "scsb_consts.svh"

// Behaviour
// - crystal select 0: primary pin is logic input; 1: oscillator amplifier enabled.
// - with crystal on, oscillator is a clock source and framing strobe reads zero.
// - reset clears crystal select.
// - receive clock mux: primary, secondary, divider, loop output.
// - reset selects primary pin for receive clock.
// - transmit clock mux: primary, secondary, divider, loop output.
// - in fm mode transmit loop clock lags receive loop clock a quarter cycle.
// - reset selects secondary pin for transmit clock.
// - secondary pin drives only if direction set and no mux uses it.
// - reset clears secondary pin direction.
// - secondary pin output: oscillator, transmit clock, divider, receive loop clock.
// - oscillator chosen but not enabled: secondary pin held high.
// - reset selects oscillator as secondary pin output.
// - sixteen-bit time constant in separate low and high write-only registers.
// - new constant used only at next counter reload, unsynchronised.
// - counter runs constant to zero, one reload cycle, toggles output.
// - divider source: primary or oscillator when 0, bus clock when 1.
// - enable starts after two counts, disable stops at once; reset clears.
module scsb_top #(
    parameter int SETTLE_CYCLES = `SCSB_SETTLE_CYCLES
) (
    input wire logic clock,
    input wire logic reset_n,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic primary_clock_pin,
    input wire logic osc_clock_in,
    input wire logic framing_strobe_pin,
    output logic osc_amp_enable,
    output logic framing_strobe,
    input wire logic secondary_clock_pin_in,
    output logic secondary_clock_pin_out,
    output logic secondary_clock_pin_oe,
    input wire logic pll_rx_clock,
    input wire logic pll_quad_clock,
    input wire logic pll_fm_mode,
    output logic rx_clock,
    output logic tx_clock,
    output logic divider_clock
);

    // ==========================================
    // reset release

    logic rst_meta_ff;
    logic rst_sync_ff;
    logic rst_n;

    // release through two flops
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            rst_meta_ff <= 1'b0;
            rst_sync_ff <= 1'b0;
        end else begin
            rst_meta_ff <= 1'b1;
            rst_sync_ff <= rst_meta_ff;
        end
    end

    assign rst_n = rst_sync_ff;

    // ==========================================
    // helpers

    // four-way clock source selection, used by both muxes
    function automatic logic pick_clock(
        input scsb_pkg::scsb_src_type sel,
        input logic primary,
        input logic secondary,
        input logic divider,
        input logic pll
    );
        logic result;
        result = 1'b0;
        unique case (sel)
            scsb_pkg::SRC_PRIMARY: result = primary;
            scsb_pkg::SRC_SECONDARY: result = secondary;
            scsb_pkg::SRC_DIVIDER: result = divider;
            scsb_pkg::SRC_PLL: result = pll;
        endcase
        return result;
    endfunction

    // ==========================================
    // registers and bus state

    scsb_pkg::scsb_mode_type mode_ff;
    logic [7:0] const_low_ff;
    logic [7:0] const_high_ff;
    logic [7:0] div_control_ff;
    logic [7:0] addr_ff;
    logic write_pend_ff;
    logic [31:0] hrdata_ff;
    logic [31:0] nxt_rdata;
    logic [7:0] wr_byte;
    logic take;
    logic take_read;
    logic wr_mode;
    logic wr_low;
    logic wr_high;
    logic wr_divctl;

    // ==========================================
    // ahb-lite slave

    // address phase accepted when selected, non-idle and bus ready
    assign take = hsel && htrans[1] && hready;
    assign take_read = take && !hwrite;
    assign hreadyout = 1'b1; // zero wait states
    assign hresp = 1'b0; // always okay
    assign hrdata = hrdata_ff;

    // data phase write decode
    assign wr_byte = hwdata[7:0];
    assign wr_mode = write_pend_ff && (addr_ff == `SCSB_OFS_CLOCK_MODE);
    assign wr_low = write_pend_ff && (addr_ff == `SCSB_OFS_CONST_LOW);
    assign wr_high = write_pend_ff && (addr_ff == `SCSB_OFS_CONST_HIGH);
    assign wr_divctl = write_pend_ff && (addr_ff == `SCSB_OFS_DIV_CONTROL);

    // address phase capture, read data registered here
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            addr_ff <= 8'h00;
            write_pend_ff <= 1'b0;
            hrdata_ff <= 32'h0000_0000;
        end else begin
            addr_ff <= haddr[7:0];
            write_pend_ff <= take && hwrite;
            if (take_read) begin
                hrdata_ff <= nxt_rdata;
            end
        end
    end

    // register writes
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            mode_ff <= scsb_pkg::scsb_mode_type'(`SCSB_CLOCK_MODE_RESET);
            const_low_ff <= 8'(`SCSB_CONST_RESET);
            const_high_ff <= 8'(`SCSB_CONST_RESET >> 8);
            div_control_ff <= `SCSB_DIV_CONTROL_RESET;
        end else begin
            if (wr_mode) begin
                mode_ff <= scsb_pkg::scsb_mode_type'(wr_byte);
            end
            if (wr_low) begin
                const_low_ff <= wr_byte;
            end
            if (wr_high) begin
                const_high_ff <= wr_byte;
            end
            if (wr_divctl) begin
                div_control_ff <= wr_byte & 8'h03;
            end
        end
    end

    // ==========================================
    // pin synchronisers

    scsb_pkg::scsb_pins_type pins;
    logic [3:0] pins_raw;
    logic [3:0] pins_level;

    assign pins_raw = {primary_clock_pin, osc_clock_in, framing_strobe_pin, secondary_clock_pin_in};
    assign pins = scsb_pkg::scsb_pins_type'(pins_level);

    scsb_sync #(
        .WIDTH(4)
    ) u_sync (
        .clock(clock),
        .reset_n(rst_n),
        .pin_in(pins_raw),
        .level_out(pins_level)
    );

    // ==========================================
    // crystal oscillator

    logic xtal_on;
    logic primary_source;
    logic [`SCSB_SETTLE_WIDTH-1:0] settle_ff;
    logic settled;

    // amplifier across primary pin and framing pin
    assign xtal_on = mode_ff.xtal_select;
    assign osc_amp_enable = xtal_on;
    assign primary_source = xtal_on ? pins.oscillator : pins.primary;
    assign framing_strobe = xtal_on ? 1'b0 : pins.framing;
    assign settled = (settle_ff == SETTLE_CYCLES[`SCSB_SETTLE_WIDTH-1:0]);

    // stabilisation timer shown in status for software
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            settle_ff <= '0;
        end else if (!xtal_on) begin
            settle_ff <= '0;
        end else if (!settled) begin
            settle_ff <= settle_ff + 1'b1;
        end
    end

    // ==========================================
    // baud rate divider

    logic div_source_bus;
    logic div_enable;
    logic div_level;
    logic div_prev_ff;
    logic div_tick;
    logic div_out;
    logic div_running;
    logic [15:0] div_count;
    logic [15:0] time_constant;

    // source: bus clock or primary/oscillator rising edges
    assign div_source_bus = div_control_ff[`SCSB_DIVCTL_SOURCE];
    assign div_enable = div_control_ff[`SCSB_DIVCTL_ENABLE];
    assign div_level = primary_source;
    assign div_tick = div_source_bus ? 1'b1 : (div_level && !div_prev_ff);
    assign time_constant = {const_high_ff, const_low_ff};

    // edge history of the divider source
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            div_prev_ff <= 1'b0;
        end else begin
            div_prev_ff <= div_level;
        end
    end

    scsb_divider u_divider (
        .clock(clock),
        .reset_n(rst_n),
        .tick(div_tick),
        .enable(div_enable),
        .time_constant(time_constant),
        .divider_out(div_out),
        .running(div_running),
        .count(div_count)
    );

    // ==========================================
    // clock multiplexers and secondary pin

    logic sec_used;
    logic pin_drive;
    logic pll_tx;
    logic nxt_rx_clock;
    logic nxt_tx_clock;
    logic nxt_pin_out;
    logic rx_clock_ff;
    logic tx_clock_ff;
    logic pin_out_ff;
    logic pin_oe_ff;
    logic div_clock_ff;

    // transmit loop clock uses quarter-cycle lagging phase in fm
    assign pll_tx = pll_fm_mode ? pll_quad_clock : pll_rx_clock;

    assign nxt_rx_clock = pick_clock(mode_ff.rx_select, primary_source, pins.secondary,
        div_out, pll_rx_clock);
    assign nxt_tx_clock = pick_clock(mode_ff.tx_select, primary_source, pins.secondary,
        div_out, pll_tx);

    // pin drives only if not used as an input clock
    assign sec_used = (mode_ff.rx_select == scsb_pkg::SRC_SECONDARY)
        || (mode_ff.tx_select == scsb_pkg::SRC_SECONDARY);
    assign pin_drive = mode_ff.pin_direction && !sec_used;

    // output source, high for oscillator while crystal is off
    assign nxt_pin_out = !pin_drive ? 1'b0 :
        (mode_ff.out_select == scsb_pkg::OUT_OSC) ? (xtal_on ? pins.oscillator : 1'b1) :
        (mode_ff.out_select == scsb_pkg::OUT_TX_CLOCK) ? nxt_tx_clock :
        (mode_ff.out_select == scsb_pkg::OUT_DIVIDER) ? div_out : pll_rx_clock;

    assign rx_clock = rx_clock_ff;
    assign tx_clock = tx_clock_ff;
    assign secondary_clock_pin_out = pin_out_ff;
    assign secondary_clock_pin_oe = pin_oe_ff;
    assign divider_clock = div_clock_ff;

    // registered clock outputs
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            rx_clock_ff <= 1'b0;
            tx_clock_ff <= 1'b0;
            pin_out_ff <= 1'b0;
            pin_oe_ff <= 1'b0;
            div_clock_ff <= 1'b0;
        end else begin
            rx_clock_ff <= nxt_rx_clock;
            tx_clock_ff <= nxt_tx_clock;
            pin_out_ff <= nxt_pin_out;
            pin_oe_ff <= pin_drive;
            div_clock_ff <= div_out;
        end
    end

    // ==========================================
    // read mux

    logic [31:0] status_word;

    // status shows pin direction, divider and oscillator state
    always_comb begin
        status_word = 32'h0000_0000;
        status_word[`SCSB_STAT_PIN_OE] = pin_oe_ff;
        status_word[`SCSB_STAT_DIV_OUT] = div_out;
        status_word[`SCSB_STAT_SETTLED] = settled;
        status_word[`SCSB_STAT_XTAL] = xtal_on;
        status_word[`SCSB_STAT_RUNNING] = div_running;
        status_word[`SCSB_STAT_COUNT_LSB +: 16] = div_count;
    end

    // write-only registers read zero, unmapped reads zero
    assign nxt_rdata = (haddr[7:0] == `SCSB_OFS_DIV_CONTROL) ? {24'h00_0000, div_control_ff} :
        (haddr[7:0] == `SCSB_OFS_STATUS) ? status_word : 32'h0000_0000;

endmodule

// ==== test/scsb_clock_partner.sv ====
// clock sources, crystal and framing pin facing the clock select block
`timescale 1ns/1ps
module scsb_clock_partner (
    input wire logic clock,
    input wire logic amp_on,
    output logic primary,
    output logic osc,
    output logic framing,
    output logic secondary,
    output logic pll_rx,
    output logic pll_quad
);
    int cnt = 0;
    // ==========================================
    // free counter paced by the bus clock
    always_ff @(posedge clock) begin
        cnt <= cnt + 1;
    end
    // square waves of distinct periods, except the two loop clocks, which share one
    assign primary = (cnt % 16) < 8;
    assign osc = amp_on && ((cnt % 20) < 10); // crystal swings only with the amplifier on
    assign framing = (cnt % 32) < 16;
    assign secondary = (cnt % 24) < 12;
    assign pll_rx = (cnt % 12) < 6;
    assign pll_quad = ((cnt + 9) % 12) < 6; // quarter cycle behind
endmodule

// ==== test/scsb_top_properties.sv ====
// port assertions for the clock select block
`timescale 1ns/1ps
module scsb_checker (
    input wire logic clock,
    input wire logic reset_n,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    input wire logic osc_amp_enable,
    input wire logic framing_strobe,
    input wire logic secondary_clock_pin_out,
    input wire logic secondary_clock_pin_oe,
    input wire logic pll_rx_clock,
    input wire logic pll_quad_clock,
    input wire logic pll_fm_mode,
    input wire logic rx_clock,
    input wire logic tx_clock,
    input wire logic divider_clock
);
    logic wr_ff;
    logic [7:0] adr_ff;
    scsb_pkg::scsb_mode_type mode_ff;
    logic enable_ff;
    logic exp_oe;
    default clocking @(posedge clock); endclocking
    default disable iff (!reset_n);
    // ==========================================
    // shadow of written mode and enable
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            wr_ff <= 1'b0;
            adr_ff <= 8'h00;
            mode_ff <= 8'h08;
            enable_ff <= 1'b0;
        end else begin
            wr_ff <= hsel && htrans[1] && hready && hwrite;
            adr_ff <= haddr[7:0];
            if (wr_ff && adr_ff == 8'h00) mode_ff <= hwdata[7:0];
            if (wr_ff && adr_ff == 8'h0c) enable_ff <= hwdata[0];
        end
    end
    // pin may drive only when no mux uses it
    assign exp_oe = mode_ff.pin_direction && mode_ff.rx_select != scsb_pkg::SRC_SECONDARY
        && mode_ff.tx_select != scsb_pkg::SRC_SECONDARY;
    property p_amp;
        mode_ff == $past(mode_ff) |-> osc_amp_enable == mode_ff.xtal_select;
    endproperty
    a_amp: assert property (p_amp) else $error("amplifier enable off mode");
    property p_framing;
        osc_amp_enable [*2] |-> !framing_strobe;
    endproperty
    a_framing: assert property (p_framing) else $error("framing not forced low");
    property p_pin_dir;
        mode_ff == $past(mode_ff) |-> secondary_clock_pin_oe == exp_oe;
    endproperty
    a_pin_dir: assert property (p_pin_dir) else $error("pin direction wrong");
    property p_pin_high;
        mode_ff == $past(mode_ff) && exp_oe && mode_ff.out_select == scsb_pkg::OUT_OSC
            && !mode_ff.xtal_select |-> secondary_clock_pin_out;
    endproperty
    a_pin_high: assert property (p_pin_high) else $error("idle oscillator pin not high");
    property p_rx_pll;
        mode_ff == $past(mode_ff) && mode_ff.rx_select == scsb_pkg::SRC_PLL |-> rx_clock == $past(pll_rx_clock);
    endproperty
    a_rx_pll: assert property (p_rx_pll) else $error("receive loop clock wrong");
    property p_tx_fm;
        mode_ff == $past(mode_ff) && mode_ff.tx_select == scsb_pkg::SRC_PLL && pll_fm_mode && $past(pll_fm_mode)
            |-> tx_clock == $past(pll_quad_clock);
    endproperty
    a_tx_fm: assert property (p_tx_fm) else $error("transmit loop phase wrong");
    property p_tx_div;
        mode_ff == $past(mode_ff) && mode_ff.tx_select == scsb_pkg::SRC_DIVIDER |-> tx_clock == divider_clock;
    endproperty
    a_tx_div: assert property (p_tx_div) else $error("transmit divider clock wrong");
    property p_div_stop;
        !enable_ff && !$past(enable_ff) |=> $stable(divider_clock);
    endproperty
    a_div_stop: assert property (p_div_stop) else $error("stopped divider toggled");
endmodule
bind scsb_top scsb_checker chk (.clock(clock), .reset_n(reset_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .osc_amp_enable(osc_amp_enable),
    .framing_strobe(framing_strobe), .secondary_clock_pin_out(secondary_clock_pin_out),
    .secondary_clock_pin_oe(secondary_clock_pin_oe), .pll_rx_clock(pll_rx_clock), .pll_quad_clock(pll_quad_clock),
    .pll_fm_mode(pll_fm_mode), .rx_clock(rx_clock), .tx_clock(tx_clock), .divider_clock(divider_clock));

// ==== test/testbench.sv ====
// self-checking bench for the clock select block
`timescale 1ns/1ps
module testbench;
    logic clock, reset_n, hsel, hwrite, hready, hreadyout, fm, pout, poe, pwire, amp, frm;
    logic rxc, txc, divc, prim, osc, fpin, sdrv, prx, pq, hold, hrsp;
    logic [1:0] htrans;
    logic [31:0] haddr, hwdata, hrdata, seen;
    int fail_count, comparisons;
    int pe[3] = '{16, 10, 12};
    assign hready = hreadyout;
    assign pwire = poe ? pout : sdrv;
    scsb_top #(.SETTLE_CYCLES(50)) dut (.clock(clock), .reset_n(reset_n), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hrsp), .primary_clock_pin(prim), .osc_clock_in(osc), .framing_strobe_pin(fpin),
        .osc_amp_enable(amp), .framing_strobe(frm), .secondary_clock_pin_in(pwire),
        .secondary_clock_pin_out(pout), .secondary_clock_pin_oe(poe), .pll_rx_clock(prx), .pll_quad_clock(pq),
        .pll_fm_mode(fm), .rx_clock(rxc), .tx_clock(txc), .divider_clock(divc));
    scsb_clock_partner partner (.clock(clock), .amp_on(amp), .primary(prim), .osc(osc), .framing(fpin),
        .secondary(sdrv), .pll_rx(prx), .pll_quad(pq));
    // ==========================================
    // clock and watchdog
    initial begin
        clock = 1'b0;
        forever #12.5 clock = ~clock;
    end
    initial begin
        #(60000 * 25);
        fail_count++;
        summarize();
    end
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            fail_count++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // one single ahb transfer, read data kept in seen
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge clock);
        hsel <= 1'b1;
        htrans <= 2'b10;
        hwrite <= wr;
        haddr <= {24'h000000, a};
        do @(posedge clock); while (hready !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        do @(posedge clock); while (hready !== 1'b1);
        seen = hrdata;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        bus(1'b1, a, {24'h000000, d});
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] mask, input logic [31:0] exp);
        bus(1'b0, a, 32'h00000000);
        check(seen & mask, exp);
    endtask
    function automatic logic pick(input int k);
        case (k)
            0: return rxc;
            1: return txc;
            2: return divc;
            default: return pwire;
        endcase
    endfunction
    // cycles between second and third rising edges, skipping a select glitch
    task automatic period(input int k, input int exp);
        int n, e, t;
        logic p, c;
        n = 0;
        e = 0;
        p = pick(k);
        for (t = 0; t < 4000 && e < 3; t++) begin
            @(negedge clock);
            c = pick(k);
            if (c && !p) e++;
            if (e == 2) n++;
            p = c;
        end
        check(32'(n), 32'(exp));
    endtask
    task automatic summarize;
        $display("comparisons %0d fail_count %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    // ==========================================
    // test sequence
    initial begin
        reset_n = 1'b0;
        hsel = 1'b0;
        haddr = 32'h00000000;
        htrans = 2'b00;
        hwrite = 1'b0;
        hwdata = 32'h00000000;
        fm = 1'b0;
        repeat (10) @(posedge clock);
        reset_n <= 1'b1;
        repeat (3) @(posedge clock);
        rd(8'h10, 32'h00000009, 32'h00000000);
        rd(8'h00, 32'hffffffff, 32'h00000000);
        rd(8'h20, 32'hffffffff, 32'h00000000);
        check(hrsp, 1'b0);
        period(0, 16);
        period(1, 24);
        wr(8'h04, 8'h03);
        wr(8'h0c, 8'h03);
        period(2, 10);
        wr(8'h00, 8'h50);
        period(0, 10);
        period(1, 10);
        wr(8'h0c, 8'h00);
        wr(8'h08, 8'h01);
        wr(8'h0c, 8'h03);
        period(2, 522);
        wr(8'h0c, 8'h00);
        wr(8'h04, 8'h01);
        wr(8'h08, 8'h00);
        wr(8'h0c, 8'h01);
        period(2, 96);
        wr(8'h0c, 8'h00);
        rd(8'h10, 32'h00000010, 32'h00000000);
        hold = divc;
        repeat (40) @(negedge clock);
        check(divc, hold);
        wr(8'h00, 8'h78);
        period(0, 12);
        fm <= 1'b1;
        period(1, 12);
        wr(8'h04, 8'h03);
        wr(8'h0c, 8'h03);
        for (int i = 0; i < 3; i++) begin
            wr(8'h00, 8'h05 + 8'(i));
            rd(8'h10, 32'h00000001, 32'h00000001);
            period(3, pe[i]);
        end
        wr(8'h00, 8'h04);
        repeat (4) @(negedge clock);
        check(pwire, 1'b1);
        wr(8'h00, 8'h0e);
        rd(8'h10, 32'h00000001, 32'h00000000);
        wr(8'h00, 8'h84);
        repeat (60) @(posedge clock);
        rd(8'h10, 32'h0000000c, 32'h0000000c);
        check(frm, 1'b0);
        period(3, 20);
        summarize();
    end
endmodule
